// ### verilog/oms_pkg.sv
package oms_pkg;
   // banks of a sixteen-lane module
   localparam int NB = 2;
   localparam int CLK_PERIOD_NS = 50;
   // least reset pulse, rounded up to cycles
   localparam int RST_MIN_NS = 10000;
   localparam int RST_MIN_CYC =
      (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // select settle time, one figure for assert and deassert
   localparam int SEL_GUARD_NS = 2000;
   localparam int SEL_GUARD_CYC =
      (SEL_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host drives twice the least width for margin
   localparam int RST_HOLD_CYC = 2 * RST_MIN_CYC;
   localparam int CW = 10;
   localparam logic [CW-1:0] RST_MIN_CNT = CW'(RST_MIN_CYC);
   localparam logic [CW-1:0] RST_HOLD_CNT = CW'(RST_HOLD_CYC);
   localparam logic [CW-1:0] SEL_GUARD_CNT = CW'(SEL_GUARD_CYC);
   localparam logic [CW-1:0] CNT_ZERO = 10'h000;
   localparam logic [CW-1:0] CNT_ONE = 10'h001;
   // management bus slave
   localparam logic [6:0] TWI_DEV_ADDR = 7'h50;
   localparam logic [3:0] BC_ZERO = 4'h0;
   localparam logic [3:0] BC_ONE = 4'h1;
   localparam logic [3:0] BC_LAST = 4'h7;
   localparam logic [3:0] BC_BYTE = 4'h8;
   localparam logic [7:0] REG_FLAGS = 8'h00;
   localparam logic [7:0] REG_LIVE = 8'h01;
   localparam logic [7:0] REG_CAP = 8'h02;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam int NFLG = 3;
   localparam int FLG_LOS = 0;
   localparam int FLG_ALT = 1;
   localparam int FLG_FAULT = 2;
   localparam logic [7:0] CAP_TX_CLK_RECOV = 8'h01;
   typedef enum logic [2:0] {
      TW_IDLE, TW_ADDR, TW_AACK, TW_WR, TW_WACK, TW_RD, TW_RACK
   } oms_twi_st_type;
   // host register map, byte addresses
   localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_TWI = 32'h0000_0004;
   localparam logic [31:0] ADDR_STAT = 32'h0000_0008;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam int HTRANS_ACT = 1;
   localparam int CTRL_SEL = 0;
   localparam int CTRL_TXDIS = 2;
   localparam int CTRL_INIT = 4;
   localparam int CTRL_RST = 6;
   localparam int CTRL_DRV = 8;
   localparam int TWI_SCL = 0;
   localparam int TWI_SDA = 2;
   localparam int ST_IRQ = 0;
   localparam int ST_LOS = 2;
   localparam int ST_ALT = 4;
   localparam int ST_PRES = 6;
   localparam int ST_GUARD = 7;
   localparam int ST_RBUSY = 8;
   localparam int ST_SCL = 10;
   localparam int ST_SDA = 12;
endpackage : oms_pkg

// ### verilog/oms_sideband_if.sv
`timescale 1ns/1ps
interface oms_sideband_if;
   import oms_pkg::*;
   // device drives: open-drain enables and clock monitor
   logic [NB-1:0] rx_signal_lost_oe;
   logic [NB-1:0] alt_port_signal_lost_oe;
   logic [NB-1:0] module_irq_n_oe;
   logic module_present_n_oe;
   logic [NB-1:0] dev_sda_oe;
   logic [NB-1:0] recovered_clk_mon_p;
   logic [NB-1:0] recovered_clk_mon_n;
   // host drives: value and enable for each control pin, enable only for scl and sda
   logic [NB-1:0] h_reset_val, h_reset_oe;
   logic [NB-1:0] h_select_val, h_select_oe;
   logic [NB-1:0] h_txdis_val, h_txdis_oe;
   logic [NB-1:0] h_init_val, h_init_oe;
   logic [NB-1:0] h_scl_oe, h_sda_oe;
   // resolved wire levels
   logic [NB-1:0] rx_signal_lost, alt_port_signal_lost;
   logic [NB-1:0] module_irq_n;
   logic module_present_n;
   logic [NB-1:0] module_reset_n, module_select_n;
   logic [NB-1:0] tx_disable, software_init_select;
   logic [NB-1:0] scl, sda;
   // host pull-ups on open-drain outputs
   assign rx_signal_lost = ~rx_signal_lost_oe;
   assign alt_port_signal_lost = ~alt_port_signal_lost_oe;
   assign module_irq_n = ~module_irq_n_oe;
   assign module_present_n = ~module_present_n_oe;
   // module pull-ups: an undriven input reads high
   assign module_reset_n = (h_reset_val & h_reset_oe) | ~h_reset_oe;
   assign module_select_n = (h_select_val & h_select_oe) | ~h_select_oe;
   assign tx_disable = (h_txdis_val & h_txdis_oe) | ~h_txdis_oe;
   assign software_init_select = (h_init_val & h_init_oe) | ~h_init_oe;
   assign scl = ~h_scl_oe;
   assign sda = ~(h_sda_oe | dev_sda_oe);
   modport dev (
      output rx_signal_lost_oe, alt_port_signal_lost_oe, module_irq_n_oe,
      output module_present_n_oe, dev_sda_oe,
      output recovered_clk_mon_p, recovered_clk_mon_n,
      input module_reset_n, module_select_n, tx_disable,
      input software_init_select, scl, sda
   );
   modport host (
      output h_reset_val, h_reset_oe, h_select_val, h_select_oe,
      output h_txdis_val, h_txdis_oe, h_init_val, h_init_oe,
      output h_scl_oe, h_sda_oe,
      input rx_signal_lost, alt_port_signal_lost, module_irq_n,
      input module_present_n, scl, sda
   );
endinterface : oms_sideband_if

// ### verilog/oms_rst_filt.sv
`timescale 1ns/1ps
module oms_rst_filt
   import oms_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pin_n,
   output logic o_reset
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic rst;
   } oms_filt_type;
   oms_filt_type r, n;
   // glitches shorter than the least width never reach the bank
   always_comb begin
      n = r;
      if (!i_pin_n) begin
         if (r.cnt != RST_MIN_CNT) begin
            n.cnt = r.cnt + CNT_ONE;
         end else begin
            n.rst = 1'b1;
         end
      end else begin
         n.cnt = CNT_ZERO;
         n.rst = 1'b0;
      end
   end
   // state register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign o_reset = r.rst;
endmodule : oms_rst_filt

// ### verilog/oms_device.sv
// Behaviour
// - primary loss output shows low optical input
// - absent loss function holds pin low
// - long reset pulse restores all defaults
// - undriven reset input reads deasserted
// - select low enables management bus slave
// - select high: no response, no acknowledge
// - host waits deassert time after deselect
// - host waits assert time after select
// - host may overlap windows of modules
// - undriven select input reads deselected
// - interrupt low on change or fault
// - interrupt released once set flags read
// - host reads source over management bus
// - optional recovered clock or aux output
// - presence output held low when inserted
// - transmit disable high or open: off
// - transmit disable low: transmitter runs unless bank held in reset
// - alternate loss output for secondary port
// - init select high software, low hardware
// - undriven init select means software init
// - two independent banks, one presence output
// - capability register reports clock recovery
`timescale 1ns/1ps
module oms_device
   import oms_pkg::*;
#(
   parameter bit LOS_ON_PIN = 1'b1
)
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [NB-1:0] I_LOS,
   input wire logic [NB-1:0] I_ALT_LOS,
   input wire logic [NB-1:0] I_FAULT,
   input wire logic [NB-1:0] I_RECOV_TICK,
   input wire logic [NB-1:0] I_AUX_SEL,
   input wire logic [NB-1:0] I_AUX_BIT,
   output logic [NB-1:0] O_TX_ENABLE,
   output logic [NB-1:0] O_SW_INIT,
   output logic [NB-1:0] O_BANK_RESET,
   oms_sideband_if.dev SB
);
   typedef struct packed {
      oms_twi_st_type st;
      logic scl_q;
      logic sda_q;
      logic [3:0] bc;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic rd;
      logic ptr_wr;
      logic nack;
      logic sda_oe;
      logic [NFLG-1:0] flags;
      logic los_q;
      logic alt_q;
      logic clk_ph;
      logic mon;
   } oms_bank_type;

   typedef struct packed {
      oms_bank_type [NB-1:0] bank;
   } oms_dev_type;

   oms_dev_type r, n;
   logic [NB-1:0] brst;

   // register file seen over the management bus
   function automatic logic [7:0] reg_read(
      input logic [7:0] ptr,
      input oms_bank_type b,
      input logic txdis,
      input logic init);
      logic [7:0] d;
      d = 8'h00;
      if (ptr == REG_FLAGS) begin
         d[NFLG-1:0] = b.flags;
      end else if (ptr == REG_LIVE) begin
         d[3:0] = {init, txdis, b.alt_q, b.los_q};
      end else if (ptr == REG_CAP) begin
         d = CAP_TX_CLK_RECOV;
      end
      return d;
   endfunction : reg_read

   // one bank: bus slave, flags, clock monitor
   function automatic oms_bank_type bank_step(
      input oms_bank_type r,
      input logic scl,
      input logic sda,
      input logic sel_n,
      input logic rst,
      input logic los,
      input logic alt,
      input logic fault,
      input logic tick,
      input logic aux_sel,
      input logic aux_bit,
      input logic txdis,
      input logic init);
      oms_bank_type n;
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic ld;
      logic [NFLG-1:0] set;
      logic [NFLG-1:0] clr;
      logic [7:0] rdat;
      n = r;
      ld = 1'b0;
      clr = '0;
      rdat = 8'h00;
      n.scl_q = scl;
      n.sda_q = sda;
      rise = scl & ~r.scl_q;
      fall = ~scl & r.scl_q;
      start = scl & r.scl_q & r.sda_q & ~sda;
      stop = scl & r.scl_q & ~r.sda_q & sda;
      if (sel_n) begin
         n.st = TW_IDLE;
         n.sda_oe = 1'b0;
      end else if (start) begin
         n.st = TW_ADDR;
         n.bc = BC_ZERO;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st = TW_IDLE;
         n.sda_oe = 1'b0;
      end else begin
         case (r.st)
            TW_ADDR, TW_WR: begin
               if (rise && r.bc != BC_BYTE) begin
                  n.sh = {r.sh[6:0], sda};
                  n.bc = r.bc + BC_ONE;
               end else if (fall && r.bc == BC_BYTE) begin
                  n.bc = BC_ZERO;
                  if (r.st == TW_WR) begin
                     // first written byte sets the pointer
                     if (r.ptr_wr) begin
                        n.ptr = r.sh;
                     end
                     n.ptr_wr = 1'b0;
                     n.st = TW_WACK;
                     n.sda_oe = 1'b1;
                  end else if (r.sh[7:1] == TWI_DEV_ADDR) begin
                     n.st = TW_AACK;
                     n.rd = r.sh[0];
                     n.ptr_wr = ~r.sh[0];
                     n.sda_oe = 1'b1;
                  end else begin
                     n.st = TW_IDLE;
                  end
               end
            end
            TW_AACK: begin
               if (fall) begin
                  n.sda_oe = 1'b0;
                  n.st = TW_WR;
                  ld = r.rd;
               end
            end
            TW_WACK: begin
               if (fall) begin
                  n.sda_oe = 1'b0;
                  n.st = TW_WR;
               end
            end
            TW_RD: begin
               if (fall) begin
                  if (r.bc == BC_LAST) begin
                     n.sda_oe = 1'b0;
                     n.st = TW_RACK;
                  end else begin
                     n.bc = r.bc + BC_ONE;
                     n.sh = {r.sh[6:0], 1'b0};
                     n.sda_oe = ~r.sh[6];
                  end
               end
            end
            TW_RACK: begin
               if (rise) begin
                  n.nack = sda;
               end else if (fall) begin
                  // a refused byte ends the read
                  n.st = r.nack ? TW_IDLE : TW_RD;
                  ld = ~r.nack;
               end
            end
            default: begin
               n.st = TW_IDLE;
            end
         endcase
      end
      if (ld) begin
         rdat = reg_read(r.ptr, r, txdis, init);
         n.sh = rdat;
         n.ptr = r.ptr + PTR_STEP;
         n.bc = BC_ZERO;
         n.st = TW_RD;
         n.sda_oe = ~rdat[7];
         if (r.ptr == REG_FLAGS) begin
            clr = r.flags;
         end
      end
      set = '0;
      set[FLG_LOS] = los ^ r.los_q;
      set[FLG_ALT] = alt ^ r.alt_q;
      set[FLG_FAULT] = fault;
      // a new event wins over the clear by a read
      n.flags = (r.flags & ~clr) | set;
      n.los_q = los;
      n.alt_q = alt;
      if (tick) begin
         n.clk_ph = ~r.clk_ph;
      end
      n.mon = aux_sel ? aux_bit : n.clk_ph;
      if (rst) begin
         n = '0;
         n.st = TW_IDLE;
         n.scl_q = scl;
         n.sda_q = sda;
         n.los_q = los;
         n.alt_q = alt;
      end
      return n;
   endfunction : bank_step

   // per-bank reset filters, each bank on its own pin
   for (genvar b = 0; b < NB; b++) begin : g_filt
      oms_rst_filt oms_rst_filt_inst (
         .i_clk(I_CLK),
         .i_rst_n(I_RST_N),
         .i_pin_n(SB.module_reset_n[b]),
         .o_reset(brst[b])
      );
   end

   // next state of both banks
   always_comb begin
      for (int b = 0; b < NB; b++) begin
         n.bank[b] = bank_step(r.bank[b], SB.scl[b], SB.sda[b],
            SB.module_select_n[b], brst[b], I_LOS[b], I_ALT_LOS[b],
            I_FAULT[b], I_RECOV_TICK[b], I_AUX_SEL[b], I_AUX_BIT[b],
            SB.tx_disable[b], SB.software_init_select[b]);
      end
   end

   // state register
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // pin and user outputs
   always_comb begin
      SB.module_present_n_oe = 1'b1;
      for (int b = 0; b < NB; b++) begin
         SB.rx_signal_lost_oe[b] = LOS_ON_PIN ? ~r.bank[b].los_q : 1'b1;
         SB.alt_port_signal_lost_oe[b] = ~r.bank[b].alt_q;
         SB.module_irq_n_oe[b] = |r.bank[b].flags;
         SB.dev_sda_oe[b] = r.bank[b].sda_oe;
         SB.recovered_clk_mon_p[b] = r.bank[b].mon;
         SB.recovered_clk_mon_n[b] = ~r.bank[b].mon;
         O_TX_ENABLE[b] = ~SB.tx_disable[b] & ~brst[b];
         O_SW_INIT[b] = SB.software_init_select[b];
      end
      O_BANK_RESET = brst;
   end
endmodule : oms_device

// ### verilog/oms_host.sv
`timescale 1ns/1ps
module oms_host
   import oms_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   oms_sideband_if.host SB
);
   typedef struct packed {
      logic [NB-1:0] sel;
      logic [NB-1:0] txdis;
      logic [NB-1:0] init;
      logic [NB-1:0] scl_lo;
      logic [NB-1:0] sda_lo;
      logic drv;
      logic [NB-1:0][CW-1:0] rcnt;
      logic [CW-1:0] guard;
      logic ap_act;
      logic ap_wr;
      logic [31:0] ap_addr;
      logic [31:0] rdata;
   } oms_host_type;

   oms_host_type r, n;
   logic [NB-1:0] rbusy;

   // register read mux; unmapped words read zero
   function automatic logic [31:0] read_word(
      input logic [31:0] a,
      input oms_host_type s,
      input logic [NB-1:0] busy);
      logic [31:0] d;
      d = WORD_ZERO;
      if (a == ADDR_CTRL) begin
         d[CTRL_SEL +: NB] = s.sel;
         d[CTRL_TXDIS +: NB] = s.txdis;
         d[CTRL_INIT +: NB] = s.init;
         d[CTRL_DRV] = s.drv;
      end else if (a == ADDR_TWI) begin
         d[TWI_SCL +: NB] = s.scl_lo;
         d[TWI_SDA +: NB] = s.sda_lo;
      end else if (a == ADDR_STAT) begin
         // interrupt seen, source read on bus
         d[ST_IRQ +: NB] = ~SB.module_irq_n;
         d[ST_LOS +: NB] = SB.rx_signal_lost;
         d[ST_ALT +: NB] = SB.alt_port_signal_lost;
         d[ST_PRES] = ~SB.module_present_n;
         d[ST_GUARD] = (s.guard != CNT_ZERO);
         d[ST_RBUSY +: NB] = busy;
         d[ST_SCL +: NB] = SB.scl;
         d[ST_SDA +: NB] = SB.sda;
      end
      return d;
   endfunction : read_word

   always_comb begin
      for (int b = 0; b < NB; b++) begin
         rbusy[b] = (r.rcnt[b] != CNT_ZERO);
      end
   end

   // bus slave, reset pulse and select guard
   always_comb begin
      n = r;
      for (int b = 0; b < NB; b++) begin
         if (rbusy[b]) begin
            n.rcnt[b] = r.rcnt[b] - CNT_ONE;
         end
      end
      if (r.ap_act && r.ap_wr) begin
         if (r.ap_addr == ADDR_CTRL) begin
            n.sel = I_HWDATA[CTRL_SEL +: NB];
            n.txdis = I_HWDATA[CTRL_TXDIS +: NB];
            n.init = I_HWDATA[CTRL_INIT +: NB];
            n.drv = I_HWDATA[CTRL_DRV];
            for (int b = 0; b < NB; b++) begin
               if (I_HWDATA[CTRL_RST + b] && !rbusy[b]) begin
                  n.rcnt[b] = RST_HOLD_CNT;
               end
            end
         end else if (r.ap_addr == ADDR_TWI) begin
            n.scl_lo = I_HWDATA[TWI_SCL +: NB];
            n.sda_lo = I_HWDATA[TWI_SDA +: NB];
         end
      end
      if (n.sel != r.sel) begin
         n.guard = SEL_GUARD_CNT;
      end else if (r.guard != CNT_ZERO) begin
         n.guard = r.guard - CNT_ONE;
      end
      // address phase; read data captured here, zero wait
      n.ap_act = I_HSEL & I_HTRANS[HTRANS_ACT] & I_HREADY;
      n.ap_wr = I_HWRITE;
      n.ap_addr = I_HADDR;
      if (n.ap_act && !I_HWRITE) begin
         n.rdata = read_word(I_HADDR, r, rbusy);
      end
   end

   // state register
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // pin drives; undriven pins fall back to module pull-ups
   always_comb begin
      O_HRDATA = r.rdata;
      O_HREADYOUT = 1'b1;
      O_HRESP = 1'b0;
      SB.h_reset_val = ~rbusy;
      SB.h_reset_oe = {NB{r.drv}} | rbusy;
      SB.h_select_val = ~r.sel;
      SB.h_select_oe = {NB{r.drv}};
      SB.h_txdis_val = r.txdis;
      SB.h_txdis_oe = {NB{r.drv}};
      SB.h_init_val = r.init;
      SB.h_init_oe = {NB{r.drv}};
      // bus traffic held off in guard
      SB.h_scl_oe = r.scl_lo & {NB{r.guard == CNT_ZERO}};
      SB.h_sda_oe = r.sda_lo & {NB{r.guard == CNT_ZERO}};
   end
endmodule : oms_host

// ### dv/oms_sideband_monitor.sv
`timescale 1ns/1ps
module oms_sideband_monitor
   import oms_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic [NB-1:0] rx_signal_lost_oe,
   input wire logic [NB-1:0] module_irq_n_oe,
   input wire logic module_present_n_oe,
   input wire logic [NB-1:0] dev_sda_oe,
   input wire logic [NB-1:0] recovered_clk_mon_p,
   input wire logic [NB-1:0] recovered_clk_mon_n,
   input wire logic [NB-1:0] module_reset_n,
   input wire logic [NB-1:0] module_select_n,
   input wire logic [NB-1:0] h_scl_oe,
   input wire logic [NB-1:0] h_sda_oe,
   input wire logic [NB-1:0] scl
);
   // two short: our window opens an edge after the host's
   localparam int GUARD_SEEN = SEL_GUARD_CYC - 2;
   logic [CW-1:0] lo_cnt_r;
   logic [CW-1:0] gd_cnt_r;
   logic [NB-1:0] sel_r;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);
   // low run on bank 0 reset pin, window after a select change
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         lo_cnt_r <= CNT_ZERO;
         gd_cnt_r <= CNT_ZERO;
         sel_r <= 2'h3;
      end else begin
         lo_cnt_r <= module_reset_n[0] ? CNT_ZERO : lo_cnt_r + CNT_ONE;
         sel_r <= module_select_n;
         if (module_select_n != sel_r) begin
            gd_cnt_r <= CW'(GUARD_SEEN);
         end else if (gd_cnt_r != CNT_ZERO) begin
            gd_cnt_r <= gd_cnt_r - CNT_ONE;
         end
      end
   end
   present_held_a: assert property (module_present_n_oe)
      else $error("presence pin released");
   mon_pair_a: assert property (
      recovered_clk_mon_p == ~recovered_clk_mon_n)
      else $error("monitor pins not complementary");
   desel_quiet_a: assert property (
      (module_select_n & $past(module_select_n) & dev_sda_oe) == 2'b00)
      else $error("data driven while deselected");
   los_irq_a: assert property (
      $changed(rx_signal_lost_oe[0]) && module_reset_n[0]
      |-> ##[0:2] module_irq_n_oe[0])
      else $error("loss change gave no interrupt");
   irq_release_a: assert property (
      ($past(module_irq_n_oe) & ~module_irq_n_oe & module_select_n
      & module_reset_n) == 2'b00)
      else $error("interrupt released without a read");
   rst_width_a: assert property (
      $rose(module_reset_n[0]) |-> lo_cnt_r >= RST_MIN_CNT)
      else $error("reset pulse too short");
   guard_mask_a: assert property (
      gd_cnt_r != CNT_ZERO |-> (h_scl_oe | h_sda_oe) == 2'b00)
      else $error("bus driven inside select guard");
   ack_on_low_a: assert property (
      $rose(dev_sda_oe[0]) |-> !module_select_n[0] && !scl[0])
      else $error("data driven while clock high or deselected");
   // main scenarios reached
   cover property ($rose(module_irq_n_oe[0]));
   cover property ($rose(dev_sda_oe[0]));
   cover property ($rose(module_reset_n[0]));
   cover property (gd_cnt_r == CNT_ONE);
endmodule : oms_sideband_monitor

// ### dv/tb_optical_module_sideband_control.sv
`timescale 1ns/1ps
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin \
   fail_count++; $display("ERROR %0t: got %h want %h", $time, g, w); \
   end end
module tb_optical_module_sideband_control;
   import oms_pkg::*;
   logic clk, rst_n, hsel, hwrite, rdph, hrdy, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, ctl, e_w, m_w, r;
   logic [NB-1:0] los, alt, fault, tick, asel, abit, txen, swi, brst, ph;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int fail_count, n_checks, cyc;
   oms_sideband_if sb ();
   oms_device oms_device_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_LOS(los),
      .I_ALT_LOS(alt), .I_FAULT(fault), .I_RECOV_TICK(tick),
      .I_AUX_SEL(asel), .I_AUX_BIT(abit), .O_TX_ENABLE(txen),
      .O_SW_INIT(swi), .O_BANK_RESET(brst), .SB(sb));
   oms_host oms_host_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
      .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .SB(sb));
   oms_sideband_monitor oms_sideband_monitor_inst (.I_CLK(clk),
      .I_RST_N(rst_n), .rx_signal_lost_oe(sb.rx_signal_lost_oe),
      .module_irq_n_oe(sb.module_irq_n_oe),
      .module_present_n_oe(sb.module_present_n_oe),
      .dev_sda_oe(sb.dev_sda_oe), .scl(sb.scl),
      .recovered_clk_mon_p(sb.recovered_clk_mon_p),
      .recovered_clk_mon_n(sb.recovered_clk_mon_n),
      .module_reset_n(sb.module_reset_n),
      .module_select_n(sb.module_select_n),
      .h_scl_oe(sb.h_scl_oe), .h_sda_oe(sb.h_sda_oe));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far above the roughly 1130 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         final_report();
      end
   end
   // each read data phase checked against the oldest note
   always @(posedge clk) begin
      if (rdph && hrdy) begin
         e_w = exp_q.pop_front();
         m_w = msk_q.pop_front();
         `CHK(hrdata & m_w, e_w & m_w)
         `CHK(hresp, 1'b0)
      end
   end
   task automatic final_report();
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   // one single transfer; called just after a rising edge
   task automatic xfer(input logic [31:0] a, input logic w,
         input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rdph <= !w;
      do @(posedge clk); while (hrdy !== 1'b1);
      rdph <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [31:0] a, e, m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      xfer(a, 1'b0, WORD_ZERO);
   endtask : rd
   // bit-bang write; extra wait keeps each level three clocks or more
   task automatic tw(input logic [3:0] v);
      xfer(ADDR_TWI, 1'b1, {28'h0, v});
      repeat (2) @(posedge clk);
   endtask : tw
   // one bus bit on both banks, line levels read while clock high
   task automatic tbit(input logic b, input logic [1:0] e);
      tw({{2{~b}}, 2'b11});
      tw({{2{~b}}, 2'b00});
      rd(ADDR_STAT, {18'h0, e, 2'b11, 10'h0}, 32'h0000_3c00);
      tw({{2{~b}}, 2'b11});
   endtask : tbit
   task automatic tbyte(input logic [7:0] v, input logic rdi,
         input logic [1:0] ack);
      for (int i = 7; i >= 0; i--) begin
         tbit(v[i] | rdi, rdi ? {1'b1, v[i]} : {2{v[i]}});
      end
      tbit(1'b1, ack);
   endtask : tbyte
   task automatic tstart();
      tw(4'h0);
      tw(4'hc);
      tw(4'hf);
   endtask : tstart
   initial begin
      {rst_n, hsel, hwrite, rdph, htrans, haddr, hwdata} = 70'h0;
      {los, alt, fault, tick, asel, abit, ph} = 14'h0;
      void'($urandom(66));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK(txen, 2'b00)
      `CHK(swi, 2'b11)
      `CHK(brst, 2'b00)
      rd(ADDR_CTRL, WORD_ZERO, 32'hffff_ffff);
      rd(32'h0000_0010, WORD_ZERO, 32'hffff_ffff);
      // clock phase toggles, then aux data
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         tick <= r[1:0];
         ph = ph ^ r[1:0];
         @(posedge clk);
         tick <= 2'b00;
         repeat (2) @(posedge clk);
         `CHK(sb.recovered_clk_mon_p, ph)
         asel <= 2'b11;
         abit <= r[3:2];
         repeat (2) @(posedge clk);
         `CHK(sb.recovered_clk_mon_p, r[3:2])
         asel <= 2'b00;
      end
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         ctl = {23'h0, 1'b1, 2'b00, r[1:0], r[3:2], 2'b00};
         xfer(ADDR_CTRL, 1'b1, ctl);
         repeat (2) @(posedge clk);
         `CHK(txen, ~r[3:2])
         `CHK(swi, r[1:0])
         rd(ADDR_CTRL, ctl, 32'hffff_ffff);
      end
      los <= 2'b11;
      alt <= 2'b11;
      for (int i = 0; i < 4; i++) begin
         repeat (3) @(posedge clk);
         rd(ADDR_STAT, {26'h0, alt, los, 2'h0}, 32'h0000_003c);
         r = $urandom;
         los <= r[1:0];
         alt <= r[3:2];
      end
      repeat (3) @(posedge clk);
      `CHK(sb.module_irq_n, 2'b00)
      los <= 2'b00;
      fault <= 2'b01;
      @(posedge clk);
      fault <= 2'b00;
      xfer(ADDR_CTRL, 1'b1, ctl | 32'h1);
      rd(ADDR_STAT, 32'h0000_0080, 32'h0000_0080);
      tw(4'h3);
      rd(ADDR_STAT, 32'h0000_0c00, 32'h0000_0c00);
      tw(4'h0);
      repeat (40) @(posedge clk);
      rd(ADDR_STAT, WORD_ZERO, 32'h0000_0080);
      // only bank 0 answers; flag read frees its irq
      tstart();
      tbyte({TWI_DEV_ADDR, 1'b0}, 1'b0, 2'b10);
      tbyte(REG_FLAGS, 1'b0, 2'b10);
      tstart();
      tbyte({TWI_DEV_ADDR, 1'b1}, 1'b0, 2'b10);
      tbyte(8'h07, 1'b1, 2'b11);
      tw(4'hf);
      tw(4'hc);
      tw(4'h0);
      // bank 0 flags read out, bank 1 still pending
      `CHK(sb.module_irq_n, 2'b01)
      xfer(ADDR_CTRL, 1'b1, ctl | 32'h0c1);
      rd(ADDR_STAT, 32'h0000_0300, 32'h0000_0300);
      repeat (150) @(posedge clk);
      `CHK(brst, 2'b00)
      repeat (100) @(posedge clk);
      `CHK(brst, 2'b11)
      `CHK(txen, 2'b00)
      repeat (200) @(posedge clk);
      `CHK(brst, 2'b00)
      `CHK(sb.module_irq_n, 2'b11)
      final_report();
   end
endmodule : tb_optical_module_sideband_control
